// ---- hw/epc_top.sv ----
// Implementation choices: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
// Exception and interrupt acceptance unit of the core.
// Assumes the pipeline reports one retiring instruction per cycle and
// obeys redirect_o in the cycle it is raised.
module epc_top
    import epc_pkg::*;
#(
    parameter int unsigned N_SRC = 8,
    parameter int unsigned N_PIN = 4
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        retire_i,
    input  wire logic [31:0] instr_i,
    input  wire logic [31:0] pc_i,
    input  wire logic        is_return_i,
    input  wire logic        is_ei_i,
    input  wire logic        is_di_i,
    input  wire logic        is_psw_load_i,
    input  wire logic [31:0] psw_load_data_i,
    input  wire logic        is_trap_i,
    input  wire logic [4:0]  trap_vec_i,
    input  wire logic        nmi_i,
    input  wire logic [N_SRC-N_PIN-1:0] int_req_i,
    input  wire logic [N_PIN-1:0] int_pin_i,
    output logic             redirect_o,
    output logic      [31:0] redirect_pc_o,
    output logic      [31:0] status_word_o,
    output logic             irq_o
);
    initial begin
        if (N_SRC > 64 || N_PIN >= N_SRC || N_PIN == 0)
            $error("epc_top: unsupported source counts");
    end

    localparam int unsigned IW = $clog2(N_SRC);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [31:0] status_word_reg;
    logic [31:0] saved_return_pc_reg;
    logic [31:0] saved_status_word_reg;
    logic [31:0] exception_cause_reg;
    logic [7:0]  in_service_levels_reg;
    logic [N_SRC-1:0] flag_reg;
    logic [N_SRC-1:0] mask_reg;
    logic [3*N_SRC-1:0] level_reg;
    logic [EV_W-1:0] ev_stat_reg;
    logic [EV_W-1:0] ev_en_reg;
    logic        nosample_reg;
    logic [4:0]  lat_cnt_reg;
    logic        lat_busy_reg;
    epc_src_t    lat_src_reg;
    logic [IW-1:0] lat_idx_reg;
    logic [2:0]  lat_lvl_reg;
    logic [N_SRC-N_PIN-1:0] int_prev_reg;
    logic [N_PIN-1:0] pin_prev_reg;

    wire logic mask_all_flag       = status_word_reg[PSW_ID_BIT];
    wire logic trap_active_flag    = status_word_reg[PSW_EP_BIT];
    wire logic nonmask_active_flag = status_word_reg[PSW_NP_BIT];

    // ------------------------------------------------------------
    // Request capture
    // ------------------------------------------------------------
    logic [N_PIN-1:0] pin_level;
    epc_pin_sync #(.W(N_PIN)) u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .pin_i   (int_pin_i),
        .level_o (pin_level)
    );

    wire logic [N_SRC-N_PIN-1:0] int_rise = int_req_i & ~int_prev_reg;
    wire logic [N_PIN-1:0] pin_rise = pin_level & ~pin_prev_reg;
    wire logic [N_SRC-1:0] req_set = {pin_rise, int_rise};

    // RQ5 illegal opcode decode
    function automatic logic is_illegal(input logic [31:0] w);
        return (&w[OP_HI_BIT:OP_LO_BIT]) &&
               (w[SUB_HI_BIT:SUB_LO_BIT] >= SUB_MIN);
    endfunction

    wire logic ilg_hit = retire_i && is_illegal(instr_i);

    // ------------------------------------------------------------
    // Arbitration
    // ------------------------------------------------------------
    logic          pick_any;
    logic [IW-1:0] pick_idx;
    logic [2:0]    pick_lvl;
    epc_level_pick #(.N(N_SRC)) u_pick (
        .req_i   (flag_reg & ~mask_reg),
        .level_i (level_reg),
        .any_o   (pick_any),
        .idx_o   (pick_idx),
        .level_o (pick_lvl)
    );

    // Lowest set in-service bit is the level now being served
    function automatic logic [3:0] top_level(input logic [7:0] isr);
        logic [3:0] r;
        r = 4'h8;
        for (int i = 7; i >= 0; i--) begin
            if (isr[i]) r = i[3:0];
        end
        return r;
    endfunction

    wire logic [3:0] cur_lvl = top_level(in_service_levels_reg);
    // RQ9 RQ13 strictly higher only
    wire logic lvl_ok = {1'b0, pick_lvl} < cur_lvl;
    // RQ14 RQ17 RQ19 maskable gating
    wire logic int_ok = pick_any && lvl_ok && !mask_all_flag &&
                        !nonmask_active_flag && !nosample_reg;
    wire logic nmi_ok = nmi_i && !nonmask_active_flag && !nosample_reg;
    // Synchronous traps come with their instruction
    wire logic trap_hit = retire_i && is_trap_i;

    // RQ8 fixed precedence
    wire epc_src_t win =
        (!lat_busy_reg && nmi_ok)   ? EPC_SRC_NMI  :
        (!lat_busy_reg && int_ok)   ? EPC_SRC_INT  :
        trap_hit                     ? EPC_SRC_TRAP :
        ilg_hit                      ? EPC_SRC_ILG  : EPC_SRC_NONE;

    wire logic start_lat = (win == EPC_SRC_NMI) || (win == EPC_SRC_INT);
    // RQ15 fixed pipeline delay within 11..18
    wire logic lat_done  = lat_busy_reg && (lat_cnt_reg == 5'(LAT_DELAY));
    wire logic take_sync = (win == EPC_SRC_TRAP) || (win == EPC_SRC_ILG);
    // RQ6 return restores from saved copies
    wire logic do_ret = retire_i && is_return_i && !take_sync && !lat_done;

    wire logic [31:0] trap_vec_addr = trap_vec_i[4] ? TRAP_VECTOR_HI
                                                    : TRAP_VECTOR_LO;
    wire logic [15:0] int_cause = INT_CAUSE_BASE + 16'({pick_idx, 4'h0});
    wire logic [31:0] int_vec = INT_VECTOR_BASE + 32'({lat_idx_reg, 4'h0});

    // ------------------------------------------------------------
    // Wishbone slave
    // ------------------------------------------------------------
    wire logic wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire logic wb_wr  = wb_req && wb_we_i && wb_sel_i[0];
    wire logic in_ctrl = wb_adr_i < 8'(4 * N_SRC);
    wire logic [IW-1:0] ctrl_idx = wb_adr_i[IW+1:2];
    wire logic [EV_W-1:0] ev_now = {do_ret, lat_done,
                                    win == EPC_SRC_TRAP, ilg_hit};
    wire logic [EV_W-1:0] ev_clr = (wb_wr && wb_adr_i == ADR_EV_CLR) ?
                                   wb_dat_i[EV_W-1:0] : '0;
    logic [31:0] rd_data;
    always_comb begin
        rd_data = 32'h0000_0000;
        if (in_ctrl) begin
            rd_data[CTRL_IF_BIT] = flag_reg[ctrl_idx];
            rd_data[CTRL_MK_BIT] = mask_reg[ctrl_idx];
            rd_data[2:0] = level_reg[3*ctrl_idx +: 3];
        end else if (wb_adr_i == ADR_PSW) rd_data = status_word_reg;
        else if (wb_adr_i == ADR_SAVED_PC) rd_data = saved_return_pc_reg;
        else if (wb_adr_i == ADR_SAVED_PSW) rd_data = saved_status_word_reg;
        else if (wb_adr_i == ADR_CAUSE) rd_data = exception_cause_reg;
        else if (wb_adr_i == ADR_ISR) rd_data = {24'h0, in_service_levels_reg};
        else if (wb_adr_i == ADR_EV_STAT) rd_data = 32'(ev_stat_reg);
        else if (wb_adr_i == ADR_EV_EN) rd_data = 32'(ev_en_reg);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= rd_data;
        end
    end

    // ------------------------------------------------------------
    // Per-source control and events
    // ------------------------------------------------------------
    // RQ12 reset masked at level 7
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_reg     <= '1;
            level_reg    <= {N_SRC{LEVEL_RESET}};
            flag_reg     <= '0;
            ev_stat_reg  <= '0;
            ev_en_reg    <= '0;
            int_prev_reg <= '0;
            pin_prev_reg <= '0;
        end else begin
            int_prev_reg <= int_req_i;
            pin_prev_reg <= pin_level;
            for (int i = 0; i < N_SRC; i++) begin
                if (wb_wr && in_ctrl && ctrl_idx == IW'(i)) begin
                    mask_reg[i] <= wb_dat_i[CTRL_MK_BIT];
                    level_reg[3*i +: 3] <= wb_dat_i[2:0];
                    flag_reg[i] <= wb_dat_i[CTRL_IF_BIT];
                end
                if (req_set[i]) flag_reg[i] <= 1'b1;
                else if (win == EPC_SRC_INT && pick_idx == IW'(i))
                    flag_reg[i] <= 1'b0;
            end
            if (wb_wr && wb_adr_i == ADR_EV_EN)
                ev_en_reg <= wb_dat_i[EV_W-1:0];
            ev_stat_reg <= (ev_stat_reg & ~ev_clr) | ev_now;
        end
    end

    assign irq_o = |(ev_stat_reg & ev_en_reg);

    // ------------------------------------------------------------
    // Core state and acceptance
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_word_reg       <= PSW_RESET;
            saved_return_pc_reg   <= 32'h0000_0000;
            saved_status_word_reg <= 32'h0000_0000;
            exception_cause_reg   <= 32'h0000_0000;
            in_service_levels_reg <= 8'h00;
            nosample_reg          <= 1'b0;
            lat_busy_reg          <= 1'b0;
            lat_cnt_reg           <= 5'h00;
            lat_src_reg           <= EPC_SRC_NONE;
            lat_idx_reg           <= '0;
            lat_lvl_reg           <= 3'h0;
            redirect_o            <= 1'b0;
            redirect_pc_o         <= RESET_VECTOR;
        end else begin
            redirect_o <= 1'b0;
            // RQ17 one-slot sampling hole
            nosample_reg <= retire_i && (is_ei_i || is_di_i || is_psw_load_i);
            if (retire_i && is_ei_i) status_word_reg[PSW_ID_BIT] <= 1'b0;
            if (retire_i && is_di_i) status_word_reg[PSW_ID_BIT] <= 1'b1;
            if (retire_i && is_psw_load_i) status_word_reg <= psw_load_data_i;
            if (start_lat) begin
                lat_busy_reg <= 1'b1;
                lat_cnt_reg  <= 5'h01;
                lat_src_reg  <= win;
                lat_idx_reg  <= pick_idx;
                lat_lvl_reg  <= pick_lvl;
                exception_cause_reg <= {16'h0000,
                    (win == EPC_SRC_NMI) ? NMI_CAUSE : int_cause};
            end else if (lat_busy_reg && !lat_done) begin
                lat_cnt_reg <= lat_cnt_reg + 5'h01;
            end
            if (lat_done) begin
                lat_busy_reg <= 1'b0;
                saved_return_pc_reg   <= pc_i;
                saved_status_word_reg <= status_word_reg;
                redirect_o <= 1'b1;
                if (lat_src_reg == EPC_SRC_NMI) begin
                    status_word_reg[PSW_NP_BIT] <= 1'b1;
                    status_word_reg[PSW_ID_BIT] <= 1'b1;
                    redirect_pc_o <= NMI_VECTOR;
                end else begin
                    // RQ18 RQ19 in-service and mask-all
                    in_service_levels_reg[lat_lvl_reg] <= 1'b1;
                    status_word_reg[PSW_ID_BIT] <= 1'b1;
                    redirect_pc_o <= int_vec;
                end
            end else if (take_sync) begin
                // RQ1 save pc and status
                saved_return_pc_reg   <= pc_i;
                saved_status_word_reg <= status_word_reg;
                // RQ3 set trap and mask flags
                status_word_reg[PSW_EP_BIT] <= 1'b1;
                status_word_reg[PSW_ID_BIT] <= 1'b1;
                redirect_o <= 1'b1;
                if (win == EPC_SRC_ILG) begin
                    // RQ2 RQ4 cause and vector
                    exception_cause_reg <= {16'h0000, ILG_CAUSE};
                    redirect_pc_o <= ILG_VECTOR;
                end else begin
                    exception_cause_reg <= {16'h0000,
                        TRAP_CAUSE_BASE + 16'(trap_vec_i)};
                    redirect_pc_o <= trap_vec_addr;
                end
            end else if (do_ret) begin
                // RQ6 RQ13 restore and resume
                status_word_reg <= saved_status_word_reg;
                redirect_pc_o   <= saved_return_pc_reg;
                redirect_o      <= 1'b1;
                // RQ18 clear top in-service level
                if (!trap_active_flag && !nonmask_active_flag &&
                    cur_lvl < 4'h8)
                    in_service_levels_reg[cur_lvl[2:0]] <= 1'b0;
            end
        end
    end

    assign status_word_o = status_word_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_ILG_SAVE: assert property (@(posedge clk_i) disable iff (rst_i) // RQ1
        (win == EPC_SRC_ILG && !lat_done) |=>
        saved_return_pc_reg == $past(pc_i))
        else $error("trap did not save pc");
    AST_ILG_CAUSE: assert property (@(posedge clk_i) disable iff (rst_i) // RQ2
        (win == EPC_SRC_ILG && !lat_done) |=>
        exception_cause_reg[15:0] == ILG_CAUSE)
        else $error("trap cause wrong");
    AST_ILG_FLAGS: assert property (@(posedge clk_i) disable iff (rst_i) // RQ3
        (win == EPC_SRC_ILG && !lat_done) |=>
        status_word_reg[PSW_EP_BIT] && status_word_reg[PSW_ID_BIT])
        else $error("trap flags not set");
    AST_ILG_VEC: assert property (@(posedge clk_i) disable iff (rst_i) // RQ4
        (win == EPC_SRC_ILG && !lat_done) |=>
        redirect_o && redirect_pc_o == ILG_VECTOR)
        else $error("trap vector wrong");
    AST_RET: assert property (@(posedge clk_i) disable iff (rst_i) // RQ6
        do_ret |=> redirect_o &&
        redirect_pc_o == $past(saved_return_pc_reg))
        else $error("return did not restore pc");
    AST_NMI_BLOCK: assert property (@(posedge clk_i) disable iff (rst_i) // RQ14
        nonmask_active_flag |-> win != EPC_SRC_INT)
        else $error("maskable taken in nmi routine");
    AST_NOSAMPLE: assert property (@(posedge clk_i) disable iff (rst_i) // RQ17
        (retire_i && is_ei_i) |=> !start_lat)
        else $error("request sampled after ei");
    // Redirect lands one edge after the counter reaches its end
    AST_LATENCY: assert property (@(posedge clk_i) disable iff (rst_i) // RQ15
        start_lat |-> ##10 redirect_o)
        else $error("latency out of range");
    AST_ID_SET: assert property (@(posedge clk_i) disable iff (rst_i) // RQ19
        (lat_done && lat_src_reg == EPC_SRC_INT) |=>
        status_word_reg[PSW_ID_BIT] && in_service_levels_reg != 8'h00)
        else $error("acceptance left mask-all clear");
endmodule

// ---- hw/epc_pkg.sv ----
// Constants and types of the exception and priority control block.
// Assumes a 50 MHz system clock and a core that hands over one
// retiring instruction per cycle at most.
//
// Behaviour
// RQ1: Illegal-opcode trap saves program counter and status word first.
// RQ2: Illegal-opcode trap writes cause 0060H into low 16 cause bits.
// RQ3: Illegal-opcode trap sets trap-active and mask-all flags.
// RQ4: Illegal-opcode trap jumps to handler address 00000060H.
// RQ5: Illegal opcode: bits 5-10 all ones, bits 23-26 from 0011B up.
// RQ6: Return with trap-active set restores pc and status from saved copies.
// RQ7: Software altering trap/nonmask flags fixes them before returning.
// RQ8: Precedence: reset, nonmaskable, maskable, software exception, trap.
// RQ9: Strictly higher priority nests; lower or equal waits pending.
// RQ10: Nesting needs mask-all clear; handler saves and restores copies.
// RQ11: Each maskable source has a level 0-7, level 0 highest.
// RQ12: After reset every source is masked and at level 7.
// RQ13: Suspended or pending work proceeds only after return executes.
// RQ14: No maskable acceptance during a nonmaskable routine.
// RQ15: Request to handler start takes 11 to 18 system clocks.
// RQ16: Pin requests add a two-clock noise filter delay.
// RQ17: No acceptance right after enable, mask or status-load instructions.
// RQ18: Acceptance sets in-service level bit; return clears highest one.
// RQ19: Maskable acceptance sets the mask-all flag automatically.
package epc_pkg;
    localparam int unsigned CLK_HZ          = 50_000_000;
    localparam logic [31:0] ILG_VECTOR      = 32'h0000_0060;
    localparam logic [15:0] ILG_CAUSE       = 16'h0060;
    localparam logic [15:0] NMI_CAUSE       = 16'h0010;
    localparam logic [31:0] NMI_VECTOR      = 32'h0000_0010;
    localparam logic [31:0] TRAP_VECTOR_LO  = 32'h0000_0040;
    localparam logic [31:0] TRAP_VECTOR_HI  = 32'h0000_0050;
    localparam logic [15:0] TRAP_CAUSE_BASE = 16'h0040;
    localparam logic [31:0] INT_VECTOR_BASE = 32'h0000_0080;
    localparam logic [15:0] INT_CAUSE_BASE  = 16'h0080;
    localparam logic [31:0] RESET_VECTOR    = 32'h0000_0000;
    localparam logic [31:0] PSW_RESET       = 32'h0000_0020;
    localparam int unsigned PSW_ID_BIT      = 5;
    localparam int unsigned PSW_EP_BIT      = 6;
    localparam int unsigned PSW_NP_BIT      = 7;
    localparam int unsigned OP_LO_BIT       = 5;
    localparam int unsigned OP_HI_BIT       = 10;
    localparam int unsigned SUB_LO_BIT      = 23;
    localparam int unsigned SUB_HI_BIT      = 26;
    localparam logic [3:0]  SUB_MIN         = 4'h3;
    localparam logic [2:0]  LEVEL_RESET     = 3'h7;
    localparam int unsigned LAT_DELAY       = 9;
    localparam int unsigned LAT_MIN_CLK     = 11;
    localparam int unsigned LAT_MAX_CLK     = 18;
    localparam int unsigned FILTER_CLK      = 2;
    // Wishbone map: per-source control words, then status and events
    localparam logic [7:0]  ADR_CTRL_BASE   = 8'h00;
    localparam logic [7:0]  ADR_PSW         = 8'h40;
    localparam logic [7:0]  ADR_SAVED_PC    = 8'h44;
    localparam logic [7:0]  ADR_SAVED_PSW   = 8'h48;
    localparam logic [7:0]  ADR_CAUSE       = 8'h4C;
    localparam logic [7:0]  ADR_ISR         = 8'h50;
    localparam logic [7:0]  ADR_EV_STAT     = 8'h54;
    localparam logic [7:0]  ADR_EV_CLR      = 8'h58;
    localparam logic [7:0]  ADR_EV_EN       = 8'h5C;
    localparam int unsigned CTRL_MK_BIT     = 6;
    localparam int unsigned CTRL_IF_BIT     = 7;
    localparam int unsigned EV_W            = 4;
    typedef enum logic [2:0] {
        EPC_SRC_NONE, EPC_SRC_NMI, EPC_SRC_INT, EPC_SRC_TRAP, EPC_SRC_ILG
    } epc_src_t;
endpackage

// ---- hw/epc_pin_sync.sv ----
`timescale 1ns/1ps
// Two-flop synchroniser plus noise filter for pin requests.
// Assumes the pin is asynchronous to clk_i.
module epc_pin_sync
    import epc_pkg::*;
#(
    parameter int unsigned W = 4
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] level_o
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;
    logic [W-1:0] hist_reg;

    // RQ16 two-clock filter
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_reg <= '0;
            sync_reg <= '0;
            hist_reg <= '0;
            level_o  <= '0;
        end else begin
            meta_reg <= pin_i;
            sync_reg <= meta_reg;
            hist_reg <= sync_reg;
            level_o  <= (sync_reg & hist_reg) |
                        (level_o & (sync_reg | hist_reg));
        end
    end
endmodule

// ---- hw/epc_level_pick.sv ----
`timescale 1ns/1ps
// Picks the best-level maskable source; ties go to the lowest index.
// Purely combinational.
module epc_level_pick
    import epc_pkg::*;
#(
    parameter int unsigned N = 8
) (
    input  wire logic [N-1:0]   req_i,
    input  wire logic [3*N-1:0] level_i,
    output logic                any_o,
    output logic [$clog2(N)-1:0] idx_o,
    output logic [2:0]          level_o
);
    // RQ11 level 0 wins
    always_comb begin
        any_o   = 1'b0;
        idx_o   = '0;
        level_o = LEVEL_RESET;
        for (int i = 0; i < N; i++) begin
            if (req_i[i] && (!any_o || level_i[3*i +: 3] < level_o)) begin
                any_o   = 1'b1;
                idx_o   = i[$clog2(N)-1:0];
                level_o = level_i[3*i +: 3];
            end
        end
    end
endmodule

// ---- sim/epc_core_model.sv ----
// Stand-in for the core pipeline: tracks the program counter.
// Assumes the bench says when an instruction retires.
`timescale 1ns/1ps
module epc_core_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        retire_i,
    input  wire logic        redirect_i,
    input  wire logic [31:0] target_i,
    output logic      [31:0] pc_o
);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pc_o <= 32'h0000_0100;
        end else if (redirect_i) begin
            pc_o <= target_i;
        end else if (retire_i) begin
            pc_o <= pc_o + 32'h0000_0004;
        end
    end
endmodule

// ---- sim/tb.sv ----
// Self-checking bench for the exception and priority control block.
// Assumes the core model follows every redirect at once.
`timescale 1ns/1ps
module tb;
    import epc_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        cyc = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0, instr = 32'h0, rdat, pc, rpc, sw, q;
    logic        ack, redir, irq, retire = 1'b0, nmi = 1'b0;
    logic [4:0]  k = 5'h00;
    logic [3:0]  ireq = 4'h0;
    logic [3:0]  pin = 4'h0;
    int          failures = 0;
    int          checks_done = 0;
    int          n;
    always #10 clk = ~clk;
    epc_top i_epc_top (
        .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .retire_i(retire), .instr_i(instr), .pc_i(pc),
        .is_return_i(k[0]), .is_ei_i(k[1]), .is_di_i(k[2]),
        .is_psw_load_i(k[3]), .psw_load_data_i(32'h0),
        .is_trap_i(k[4]), .trap_vec_i(5'h00), .nmi_i(nmi),
        .int_req_i(ireq), .int_pin_i(pin), .redirect_o(redir),
        .redirect_pc_o(rpc), .status_word_o(sw), .irq_o(irq));
    epc_core_model i_epc_core_model (.clk_i(clk), .rst_i(rst),
        .retire_i(retire), .redirect_i(redir), .target_i(rpc), .pc_o(pc));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        int c;
        c = 0;
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk);
            c++;
        end while (ack !== 1'b1 && c < 20);
        if (ack !== 1'b1) failures++;
        q = rdat;
        cyc <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rt(input logic [31:0] i, input logic [4:0] f);
        retire <= 1'b1;
        instr <= i;
        k <= f;
        @(posedge clk);
        retire <= 1'b0;
        k <= 5'h00;
    endtask
    // Waits for a redirect pulse, counting edges into n
    task automatic wr();
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (redir !== 1'b1 && n < 40);
        if (redir !== 1'b1) failures++;
    endtask
    task automatic t_reset();
        for (int i = 0; i < 8; i++) begin
            wb(1'b0, ADR_CTRL_BASE + 8'(4 * i), 32'h0);
            chk(q, 32'h47);
        end
    endtask
    task automatic t_illegal(input logic [3:0] sub, input logic bad);
        logic [31:0] p0, s0;
        p0 = pc;
        s0 = sw;
        rt({5'h00, sub, 12'h000, 6'h3F, 5'h00}, 5'h00);
        if (!bad) begin
            repeat (3) begin
                @(posedge clk);
                chk({31'h0, redir}, 32'h0);
            end
            return;
        end
        wr();
        chk(rpc, ILG_VECTOR);
        @(posedge clk);
        chk(sw & 32'h60, 32'h60);
        wb(1'b0, ADR_SAVED_PC, 32'h0);
        chk(q, p0);
        wb(1'b0, ADR_SAVED_PSW, 32'h0);
        chk(q, s0);
        wb(1'b0, ADR_CAUSE, 32'h0);
        chk({16'h0, q[15:0]}, {16'h0, ILG_CAUSE});
        rt(32'h0, 5'h01);
        wr();
        chk(rpc, p0);
        @(posedge clk);
        chk(sw, s0);
    endtask
    task automatic t_int();
        wb(1'b1, ADR_CTRL_BASE, 32'h3);
        rt(32'h0, 5'h02);
        @(posedge clk);
        ireq[0] <= 1'b1;
        wr();
        chk({31'h0, n >= LAT_MIN_CLK && n <= LAT_MAX_CLK}, 32'h1);
        chk(rpc, INT_VECTOR_BASE);
        ireq[0] <= 1'b0;
        @(posedge clk);
        chk(sw & 32'h20, 32'h20);
        wb(1'b0, ADR_ISR, 32'h0);
        chk(q, 32'h8);
        // Equal level must wait even with mask-all cleared
        wb(1'b1, ADR_CTRL_BASE + 8'h04, 32'h3);
        rt(32'h0, 5'h02);
        ireq[1] <= 1'b1;
        repeat (15) begin
            @(posedge clk);
            chk({31'h0, redir}, 32'h0);
        end
        rt(32'h0, 5'h01);
        wr();
        wb(1'b0, ADR_ISR, 32'h0);
        chk(q, 32'h0);
        wr();
        chk(rpc, INT_VECTOR_BASE + 32'h10);
        ireq[1] <= 1'b0;
        rt(32'h0, 5'h01);
        wr();
    endtask
    task automatic t_prio();
        rt(32'h0, 5'h02);
        @(posedge clk);
        nmi <= 1'b1;
        ireq[0] <= 1'b1;
        wr();
        chk(rpc, NMI_VECTOR);
        nmi <= 1'b0;
        // Mask-all cleared, so only the nonmaskable state holds it off
        rt(32'h0, 5'h02);
        repeat (20) begin
            @(posedge clk);
            chk({31'h0, redir}, 32'h0);
        end
        rt(32'h0, 5'h01);
        wr();
        wr();
        chk(rpc, INT_VECTOR_BASE);
        ireq[0] <= 1'b0;
        rt(32'h0, 5'h01);
        wr();
    endtask
    task automatic t_trap();
        logic [31:0] p0;
        p0 = pc;
        // Software exception outranks the illegal opcode it rides on
        rt({5'h00, 4'h3, 12'h000, 6'h3F, 5'h00}, 5'h10);
        wr();
        chk(rpc, TRAP_VECTOR_LO);
        wb(1'b0, ADR_CAUSE, 32'h0);
        chk({16'h0, q[15:0]}, {16'h0, TRAP_CAUSE_BASE});
        rt(32'h0, 5'h01);
        wr();
        chk(rpc, p0);
    endtask
    task automatic t_pin();
        rt(32'h0, 5'h02);
        wb(1'b1, ADR_CTRL_BASE + 8'h10, 32'h3);
        // A one-cycle pulse must die in the filter
        pin[0] <= 1'b1;
        @(posedge clk);
        pin[0] <= 1'b0;
        repeat (20) begin
            @(posedge clk);
            chk({31'h0, redir}, 32'h0);
        end
        pin[0] <= 1'b1;
        wr();
        chk({31'h0, n >= LAT_MIN_CLK + FILTER_CLK &&
             n <= LAT_MAX_CLK + FILTER_CLK}, 32'h1);
        chk(rpc, INT_VECTOR_BASE + 32'h40);
        pin[0] <= 1'b0;
        rt(32'h0, 5'h01);
        wr();
    endtask
    task automatic t_events();
        wb(1'b0, ADR_EV_STAT, 32'h0);
        chk(q, 32'hF);
        chk({31'h0, irq}, 32'h0);
        wb(1'b1, ADR_EV_EN, 32'h4);
        chk({31'h0, irq}, 32'h1);
        wb(1'b1, ADR_EV_CLR, 32'hF);
        chk({31'h0, irq}, 32'h0);
        wb(1'b0, 8'h80, 32'h0);
        chk(q, 32'h0);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_illegal(4'h2, 1'b0);
        t_illegal(4'h3, 1'b1);
        t_illegal(4'hF, 1'b1);
        t_trap();
        t_int();
        t_prio();
        t_pin();
        t_events();
        tally_and_finish();
    end
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        tally_and_finish();
    end
endmodule
